// *** hw/comparator_input_select_pkg.sv ***
// constants for the comparator input-select registers and switch decoding
package comparator_input_select_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] SFR_PAGE_COMP          = 8'h00;
   localparam logic [7:0] ADDR_COMP1_INPUT_SEL   = 8'h9e;
   localparam logic [7:0] ADDR_COMP0_INPUT_SEL   = 8'h9f;
   localparam logic [7:0] INPUT_SELECT_RESET     = 8'hff;
   localparam logic [7:0] READ_DATA_RESET        = 8'h00;

   // ------------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------------
   localparam int         NEG_FIELD_LSB          = 4;
   localparam int         POS_FIELD_LSB          = 0;
   localparam int         FIELD_WIDTH            = 4;
   localparam int         CODE_COUNT             = 16;

   // ------------------------------------------------------------------
   // select codes
   // ------------------------------------------------------------------
   localparam logic [3:0] CODE_TOUCH_REF         = 4'hc;
   localparam logic [3:0] CODE_HALF_SUPPLY       = 4'hd;
   localparam logic [3:0] CODE_NEG_DIGITAL_SUP   = 4'he;
   localparam logic [3:0] CODE_NEG_GROUND        = 4'hf;
   localparam logic [3:0] CODE_POS_BATTERY       = 4'he;
   localparam logic [3:0] CODE_POS_MAIN_SUPPLY   = 4'hf;

   // one bit per code that closes a switch; zero bits are reserved codes
   localparam logic [15:0] NEG_VALID_CODES       = 16'hf04f;
   localparam logic [15:0] POS_VALID_CODES       = 16'hf0cf;

   // switch vectors after reset: code 1111 on every side
   localparam logic [15:0] SWITCH_RESET          = 16'h8000;
   localparam logic        DIVIDER_RESET         = 1'b0;

endpackage

// *** hw/select_decoder.sv ***
// one-hot switch decoder for one multiplexer side, reserved codes open
`timescale 1ns/1ns
module select_decoder #(
   parameter int          WIDTH       = 4,
   parameter logic [15:0] VALID_CODES = 16'hffff
) (
   input  wire logic [WIDTH-1:0]      code,
   output logic      [(1<<WIDTH)-1:0] switchOn,
   output logic                       halfSupply
);

   if (WIDTH != comparator_input_select_pkg::FIELD_WIDTH) begin : g_bad_width
      $error("select_decoder: WIDTH must equal the select field width");
   end

   always_comb begin
      switchOn       = '0;
      // reserved code leaves every switch open
      switchOn[code] = VALID_CODES[code]; // R10
      halfSupply     = (code == comparator_input_select_pkg::CODE_HALF_SUPPLY); // R9
   end

endmodule // select_decoder

// *** hw/comparator_input_select.sv ***
// input-select registers for both comparators and their switch drive
//
// Contract
// R1 - comparator0 select register, 8-bit RW, page 0x0 address 0x9F, resets all ones.
// R2 - comparator0 bits 7:4 pick negative pin P0.1/P0.3/P0.5/P0.7/P1.5; rest reserved.
// R3 - negative codes 1100..1111: touch reference, half supply, digital supply, ground.
// R4 - comparator0 bits 3:0 pick positive pin P0.0/P0.2/P0.4/P0.6/P1.4/P1.6.
// R5 - positive codes 1100..1111: touch reference, half supply, battery, main supply.
// R6 - comparator1 select register, 8-bit RW, page 0x0 address 0x9E, resets all ones.
// R7 - comparator1 bits 7:4 decode negative input exactly like comparator0.
// R8 - comparator1 bits 3:0 decode positive input exactly like comparator0.
// R9 - half-supply divider enabled only while some field holds the half-supply code.
// R10 - reserved code connects nothing but value is stored and read back.
`timescale 1ns/1ns
module comparator_input_select (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // special-function register port
   input  wire logic [7:0]  sfrPage,
   input  wire logic [7:0]  sfrAddr,
   input  wire logic        sfrWriteEn,
   input  wire logic        sfrReadEn,
   input  wire logic [7:0]  sfrWriteData,
   output logic      [7:0]  sfrReadData,
   output logic             sfrReadHit,
   // stored select fields
   output logic      [3:0]  comp0_negative_select,
   output logic      [3:0]  comp0_positive_select,
   output logic      [3:0]  comp1_negative_select,
   output logic      [3:0]  comp1_positive_select,
   // analog switch enables, one per code
   output logic      [15:0] comp0NegativeSwitch,
   output logic      [15:0] comp0PositiveSwitch,
   output logic      [15:0] comp1NegativeSwitch,
   output logic      [15:0] comp1PositiveSwitch,
   output logic             halfSupplyDividerEn
);

   localparam int FW = comparator_input_select_pkg::FIELD_WIDTH;
   localparam int NL = comparator_input_select_pkg::NEG_FIELD_LSB;
   localparam int PL = comparator_input_select_pkg::POS_FIELD_LSB;

   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   // both fields must fit the 8-bit register without overlapping
   if (NL + FW > 8 || PL + FW > NL) begin : g_bad_layout
      $error("comparator_input_select: select fields do not fit the register");
   end
   // each decoder drives one switch per code
   if (comparator_input_select_pkg::CODE_COUNT != (1 << FW)) begin : g_bad_count
      $error("comparator_input_select: code count does not match field width");
   end
   // switch ports are fixed at sixteen lines per side
   if (comparator_input_select_pkg::CODE_COUNT != 16) begin : g_bad_switch
      $error("comparator_input_select: switch vectors need sixteen codes");
   end

   // ------------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------------
   // only page 0x0 decodes; other pages fall through silently
   logic       pageHit;
   logic       hitComp0;
   logic       hitComp1;

   assign pageHit  = (sfrPage == comparator_input_select_pkg::SFR_PAGE_COMP);
   assign hitComp0 = pageHit && (sfrAddr == comparator_input_select_pkg::ADDR_COMP0_INPUT_SEL);
   assign hitComp1 = pageHit && (sfrAddr == comparator_input_select_pkg::ADDR_COMP1_INPUT_SEL);

   // ------------------------------------------------------------------
   // select registers
   // ------------------------------------------------------------------
   // reset leaves code 1111 on every side: ground and main supply
   logic [7:0] comp0Sel_q;
   logic [7:0] comp0Sel_d;
   logic [7:0] comp1Sel_q;
   logic [7:0] comp1Sel_d;
   logic [7:0] readData_q;
   logic [7:0] readData_d;
   logic       readHit_q;
   logic       readHit_d;

   always_comb begin
      comp0Sel_d = comp0Sel_q;
      comp1Sel_d = comp1Sel_q;
      // every code is stored, reserved or not
      if (sfrWriteEn && hitComp0) begin
         comp0Sel_d = sfrWriteData; // R1 R10
      end
      if (sfrWriteEn && hitComp1) begin
         comp1Sel_d = sfrWriteData; // R6 R10
      end
      // a read returns the value held before any write in the same cycle
      // hit flag lets software tell a stored zero from an unmapped read
      readHit_d  = sfrReadEn && (hitComp0 || hitComp1);
      readData_d = 8'h00;
      if (sfrReadEn && hitComp0) begin
         readData_d = comp0Sel_q; // R1
      end else if (sfrReadEn && hitComp1) begin
         readData_d = comp1Sel_q; // R6
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         comp0Sel_q <= comparator_input_select_pkg::INPUT_SELECT_RESET; // R1
         comp1Sel_q <= comparator_input_select_pkg::INPUT_SELECT_RESET; // R6
         readData_q <= comparator_input_select_pkg::READ_DATA_RESET;
         readHit_q  <= 1'b0;
      end else begin
         comp0Sel_q <= comp0Sel_d;
         comp1Sel_q <= comp1Sel_d;
         readData_q <= readData_d;
         readHit_q  <= readHit_d;
      end
   end

   // read data arrives one cycle after the strobe and stands for one cycle
   assign sfrReadData           = readData_q;
   assign sfrReadHit            = readHit_q;
   assign comp0_negative_select = comp0Sel_q[NL+FW-1:NL];
   assign comp0_positive_select = comp0Sel_q[PL+FW-1:PL];
   assign comp1_negative_select = comp1Sel_q[NL+FW-1:NL];
   assign comp1_positive_select = comp1Sel_q[PL+FW-1:PL];

   // ------------------------------------------------------------------
   // switch decoding
   // ------------------------------------------------------------------
   // decoders are pure logic; a reserved code yields an all-open vector
   logic [15:0] c0NegDec;
   logic [15:0] c0PosDec;
   logic [15:0] c1NegDec;
   logic [15:0] c1PosDec;
   logic [3:0]  halfHit;

   select_decoder #(
      .WIDTH       (FW),
      .VALID_CODES (comparator_input_select_pkg::NEG_VALID_CODES)
   ) u_comp0_neg (
      .code        (comp0Sel_q[NL+FW-1:NL]), // R2 R3
      .switchOn    (c0NegDec),
      .halfSupply  (halfHit[0])
   );

   select_decoder #(
      .WIDTH       (FW),
      .VALID_CODES (comparator_input_select_pkg::POS_VALID_CODES)
   ) u_comp0_pos (
      .code        (comp0Sel_q[PL+FW-1:PL]), // R4 R5
      .switchOn    (c0PosDec),
      .halfSupply  (halfHit[1])
   );

   // comparator1 shares the comparator0 code tables
   select_decoder #(
      .WIDTH       (FW),
      .VALID_CODES (comparator_input_select_pkg::NEG_VALID_CODES)
   ) u_comp1_neg (
      .code        (comp1Sel_q[NL+FW-1:NL]), // R7
      .switchOn    (c1NegDec),
      .halfSupply  (halfHit[2])
   );

   select_decoder #(
      .WIDTH       (FW),
      .VALID_CODES (comparator_input_select_pkg::POS_VALID_CODES)
   ) u_comp1_pos (
      .code        (comp1Sel_q[PL+FW-1:PL]), // R8
      .switchOn    (c1PosDec),
      .halfSupply  (halfHit[3])
   );

   // ------------------------------------------------------------------
   // registered switch drive
   // ------------------------------------------------------------------
   // registering adds one cycle of latency but keeps decode glitches
   // off the analog switch gates
   logic [15:0] c0NegSw_q;
   logic [15:0] c0NegSw_d;
   logic [15:0] c0PosSw_q;
   logic [15:0] c0PosSw_d;
   logic [15:0] c1NegSw_q;
   logic [15:0] c1NegSw_d;
   logic [15:0] c1PosSw_q;
   logic [15:0] c1PosSw_d;
   logic        divider_q;
   logic        divider_d;

   always_comb begin
      c0NegSw_d = c0NegDec;
      c0PosSw_d = c0PosDec;
      c1NegSw_d = c1NegDec;
      c1PosSw_d = c1PosDec;
      // divider burns current, so only on while someone selects it
      divider_d = |halfHit; // R9
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         c0NegSw_q <= comparator_input_select_pkg::SWITCH_RESET;
         c0PosSw_q <= comparator_input_select_pkg::SWITCH_RESET;
         c1NegSw_q <= comparator_input_select_pkg::SWITCH_RESET;
         c1PosSw_q <= comparator_input_select_pkg::SWITCH_RESET;
         divider_q <= comparator_input_select_pkg::DIVIDER_RESET;
      end else begin
         c0NegSw_q <= c0NegSw_d;
         c0PosSw_q <= c0PosSw_d;
         c1NegSw_q <= c1NegSw_d;
         c1PosSw_q <= c1PosSw_d;
         divider_q <= divider_d;
      end
   end

   // switches and divider follow a write two cycles after its strobe
   assign comp0NegativeSwitch = c0NegSw_q;
   assign comp0PositiveSwitch = c0PosSw_q;
   assign comp1NegativeSwitch = c1NegSw_q;
   assign comp1PositiveSwitch = c1PosSw_q;
   assign halfSupplyDividerEn = divider_q;

endmodule // comparator_input_select

// *** verification/comparator_input_select_chk.sv ***
// checker for the comparator input-select register port and switch drive
`timescale 1ns/1ns
module comparator_input_select_chk (
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic        sfrWriteEn,
   input wire logic        sfrReadEn,
   input wire logic        sfrReadHit,
   input wire logic        halfSupplyDividerEn,
   input wire logic [7:0]  sfrPage,
   input wire logic [7:0]  sfrAddr,
   input wire logic [7:0]  sfrWriteData,
   input wire logic [7:0]  sfrReadData,
   input wire logic [3:0]  comp0_negative_select,
   input wire logic [3:0]  comp0_positive_select,
   input wire logic [3:0]  comp1_negative_select,
   input wire logic [3:0]  comp1_positive_select,
   input wire logic [15:0] comp0NegativeSwitch,
   input wire logic [15:0] comp0PositiveSwitch,
   input wire logic [15:0] comp1NegativeSwitch,
   input wire logic [15:0] comp1PositiveSwitch
);
   // ----
   // properties
   // ----
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic       hit0, hit1;
   logic [7:0] sel0, sel1;
   assign hit0 = sfrPage == 8'h00 && sfrAddr == 8'h9f;
   assign hit1 = sfrPage == 8'h00 && sfrAddr == 8'h9e;
   assign sel0 = {comp0_negative_select, comp0_positive_select};
   assign sel1 = {comp1_negative_select, comp1_positive_select};
   logic       halfSel;
   assign halfSel = sel0[7:4] == 4'hd || sel0[3:0] == 4'hd || sel1[7:4] == 4'hd
      || sel1[3:0] == 4'hd;
   // reserved codes must leave every switch open
   function automatic logic [15:0] dec(input logic [3:0] c, input logic [15:0] m);
      return m[c] ? 16'h0001 << c : 16'h0000;
   endfunction
   a_reset_all_ones: assert property ($rose(reset_n) |-> sel0 == 8'hff && sel1 == 8'hff)
      else $error("select not all ones after reset");
   a_write0_stores: assert property (sfrWriteEn && hit0 |=> sel0 == $past(sfrWriteData))
      else $error("comparator0 select write lost");
   a_write1_stores: assert property (sfrWriteEn && hit1 |=> sel1 == $past(sfrWriteData))
      else $error("comparator1 select write lost");
   a_fields_hold: assert property (!(sfrWriteEn && (hit0 || hit1)) |=> $stable({sel0, sel1}))
      else $error("select changed without a write");
   a_read_back: assert property (sfrReadEn && (hit0 || hit1)
      |=> sfrReadHit && sfrReadData == ($past(hit0) ? $past(sel0) : $past(sel1)))
      else $error("read data wrong");
   a_read_miss: assert property (sfrReadEn && !hit0 && !hit1 |=> !sfrReadHit && sfrReadData == 8'h00)
      else $error("unmapped read answered");
   a_neg0_switch: assert property (comp0NegativeSwitch ==
      dec($past(comp0_negative_select), comparator_input_select_pkg::NEG_VALID_CODES))
      else $error("comparator0 negative switch wrong");
   a_pos0_switch: assert property (comp0PositiveSwitch ==
      dec($past(comp0_positive_select), comparator_input_select_pkg::POS_VALID_CODES))
      else $error("comparator0 positive switch wrong");
   a_neg1_switch: assert property (comp1NegativeSwitch ==
      dec($past(comp1_negative_select), comparator_input_select_pkg::NEG_VALID_CODES))
      else $error("comparator1 negative switch wrong");
   a_pos1_switch: assert property (comp1PositiveSwitch ==
      dec($past(comp1_positive_select), comparator_input_select_pkg::POS_VALID_CODES))
      else $error("comparator1 positive switch wrong");
   a_half_divider: assert property (halfSupplyDividerEn == $past(halfSel))
      else $error("divider enable wrong");
   c_write_hit: cover property (sfrWriteEn && hit0);
   c_reserved_open: cover property (sfrWriteEn && hit0 ##2 comp0NegativeSwitch == 16'h0000);
   c_read_hit: cover property (sfrReadHit);
   c_divider_on: cover property ($rose(halfSupplyDividerEn));
endmodule // comparator_input_select_chk

bind comparator_input_select comparator_input_select_chk chk (
   .ref_clk               (ref_clk),
   .reset_n               (reset_n),
   .sfrWriteEn            (sfrWriteEn),
   .sfrReadEn             (sfrReadEn),
   .sfrReadHit            (sfrReadHit),
   .halfSupplyDividerEn   (halfSupplyDividerEn),
   .sfrPage               (sfrPage),
   .sfrAddr               (sfrAddr),
   .sfrWriteData          (sfrWriteData),
   .sfrReadData           (sfrReadData),
   .comp0_negative_select (comp0_negative_select),
   .comp0_positive_select (comp0_positive_select),
   .comp1_negative_select (comp1_negative_select),
   .comp1_positive_select (comp1_positive_select),
   .comp0NegativeSwitch   (comp0NegativeSwitch),
   .comp0PositiveSwitch   (comp0PositiveSwitch),
   .comp1NegativeSwitch   (comp1NegativeSwitch),
   .comp1PositiveSwitch   (comp1PositiveSwitch)
);

// *** verification/analog_mux_model.sv ***
// behavioural model of the four analog input multiplexers
`timescale 1ns/1ns
module analog_mux_model (
   input  wire logic [63:0] sw,
   output logic      [19:0] tap
);
   // ----
   // tap per side = {connected, code}; two closed switches short, so read as open
   // ----
   always_comb begin
      tap = 20'h00000;
      for (int s = 0; s < 4; s++)
         for (int c = 0; c < 16; c++)
            if (sw[16*s+c] && $countones(sw[16*s+:16]) == 1) tap[5*s+:5] = {1'b1, 4'(c)};
   end
endmodule // analog_mux_model

// *** verification/tb_comparator_input_select.sv ***
// self-checking bench for the comparator input-select registers
`timescale 1ns/1ns
module tb_comparator_input_select;
   logic        ref_clk, reset_n, sfrWriteEn, sfrReadEn, sfrReadHit, halfSupplyDividerEn;
   logic [7:0]  sfrPage, sfrAddr, sfrWriteData, sfrReadData;
   logic [3:0]  comp0_negative_select, comp0_positive_select;
   logic [3:0]  comp1_negative_select, comp1_positive_select;
   logic [15:0] comp0NegativeSwitch, comp0PositiveSwitch, comp1NegativeSwitch, comp1PositiveSwitch;
   logic [19:0] tap;
   logic [7:0]  sh[2];
   logic [7:0]  expQ[$];
   int          failures = 0, tests_run = 0, cycles = 0;
   integer      seed = 32'hed2a29f0;
   // ----
   // design and far side
   // ----
   comparator_input_select DUT (
      .ref_clk               (ref_clk),
      .reset_n               (reset_n),
      .sfrPage               (sfrPage),
      .sfrAddr               (sfrAddr),
      .sfrWriteEn            (sfrWriteEn),
      .sfrReadEn             (sfrReadEn),
      .sfrWriteData          (sfrWriteData),
      .sfrReadData           (sfrReadData),
      .sfrReadHit            (sfrReadHit),
      .comp0_negative_select (comp0_negative_select),
      .comp0_positive_select (comp0_positive_select),
      .comp1_negative_select (comp1_negative_select),
      .comp1_positive_select (comp1_positive_select),
      .comp0NegativeSwitch   (comp0NegativeSwitch),
      .comp0PositiveSwitch   (comp0PositiveSwitch),
      .comp1NegativeSwitch   (comp1NegativeSwitch),
      .comp1PositiveSwitch   (comp1PositiveSwitch),
      .halfSupplyDividerEn   (halfSupplyDividerEn)
   );
   analog_mux_model mux (.sw({comp0NegativeSwitch, comp0PositiveSwitch,
      comp1NegativeSwitch, comp1PositiveSwitch}), .tap(tap));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         summarize();
      end
   end
   task automatic summarize;
      if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one access per cycle; strobes stay up until the next call overwrites them
   task automatic acc(input logic we, re, input logic [7:0] pg, ad, d);
      logic hit;
      hit = pg == 8'h00 && ad[7:1] == 7'h4f;
      if (re && hit) expQ.push_back(sh[ad[0]]);
      if (we && hit) sh[ad[0]] = d;
      sfrWriteEn = we;
      sfrReadEn = re;
      sfrPage = pg;
      sfrAddr = ad;
      sfrWriteData = d;
      @(posedge ref_clk);
      #1;
   endtask
   function automatic logic [4:0] ex(input logic [3:0] c, input logic neg);
      logic [15:0] m;
      m = neg ? comparator_input_select_pkg::NEG_VALID_CODES
              : comparator_input_select_pkg::POS_VALID_CODES;
      return m[c] ? {1'b1, c} : 5'h00;
   endfunction
   task automatic taps;
      logic [19:0] e;
      logic [15:0] s;
      logic        h;
      acc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      e = {ex(sh[1][7:4], 1'b1), ex(sh[1][3:0], 1'b0), ex(sh[0][7:4], 1'b1),
           ex(sh[0][3:0], 1'b0)};
      s = {comp0_negative_select, comp0_positive_select, comp1_negative_select,
           comp1_positive_select};
      h = sh[0][7:4] == 4'hd || sh[0][3:0] == 4'hd || sh[1][7:4] == 4'hd
          || sh[1][3:0] == 4'hd;
      check(tap, e);
      check(20'(s), 20'({sh[1], sh[0]}));
      check(20'(halfSupplyDividerEn), 20'(h));
   endtask
   always @(negedge ref_clk)
      if (sfrReadHit === 1'b1) begin
         if (expQ.size() == 0) check(20'h1, 20'h0);
         else check(20'(sfrReadData), 20'(expQ.pop_front()));
      end
   // ----
   // sequence
   // ----
   initial begin
      reset_n = 1'b0;
      sfrWriteEn = 1'b0;
      sfrReadEn = 1'b0;
      sfrPage = 8'h00;
      sfrAddr = 8'h00;
      sfrWriteData = 8'h00;
      for (int r = 0; r < 2; r++) begin
         sh[0] = 8'hff;
         sh[1] = 8'hff;
         repeat (r ? 1 : 6) @(posedge ref_clk);
         #1;
         reset_n = 1'b1;
         acc(1'b0, 1'b1, 8'h00, 8'h9f, 8'h00);
         acc(1'b0, 1'b1, 8'h00, 8'h9e, 8'h00);
         taps();
         for (int i = 0; i < (r ? 0 : 256); i++) begin
            acc(1'b1, 1'b0, 8'h00, 8'h9f, i[7:0]);
            acc(1'b1, 1'b1, 8'h00, 8'h9e, 8'($random(seed)));
            acc(1'b0, 1'b1, 8'h00, 8'h9f, 8'h00);
            taps();
         end
         acc(1'b1, 1'b1, 8'h01, 8'h9f, 8'h5a);
         acc(1'b1, 1'b1, 8'h00, 8'h9d, 8'h5a);
         acc(1'b0, 1'b1, 8'h00, 8'h9f, 8'h00);
         taps();
         reset_n = 1'b0;
      end
      check(20'(expQ.size()), 20'h0);
      summarize();
   end
endmodule // tb_comparator_input_select
